/* File: hw/msld_pkg.sv */
`default_nettype none
package msld_pkg;
   localparam int CNT_W         = 24;
   localparam int CLK_HZ        = 40_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int FLASH_HALF_MS = 250;
   localparam int STRETCH_MS    = 50;
   localparam int N_SER         = 4;
   localparam int N_ETH         = 2;
   localparam int N_COMM        = 6;
   localparam int N_IRQ         = 3;
   localparam int ADDR_W        = 8;

   localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] A_LED_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] A_IRQ_EN   = 8'h0c;
   localparam logic [ADDR_W-1:0] A_IRQ_CLR  = 8'h10;

   localparam int CTRL_COMM_EN = 0;
   localparam logic CTRL_COMM_EN_RST = 1'h1;
   localparam int IRQ_FAIL = 0;
   localparam int IRQ_CFG  = 1;
   localparam int IRQ_MODE = 2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   typedef enum logic [2:0] {
      BUILD_EARLY = 3'h1,
      BUILD_MID   = 3'h2,
      BUILD_LATE  = 3'h4
   } msld_build_type;

   typedef struct packed {
      logic [N_COMM-1:0] tx;
      logic [N_COMM-1:0] rx;
   } msld_act_type;

   typedef struct packed {
      logic             slice_fail;
      logic             active;
      logic             standby;
      logic             cfg_loaded;
      logic [N_ETH-1:0] eth_link;
   } msld_core_type;

   typedef struct packed {
      logic              health_r;
      logic              health_g;
      logic              active_g;
      logic              standby_g;
      logic              config_g;
      logic [N_COMM-1:0] red;
      logic [N_COMM-1:0] green;
   } msld_led_type;

   typedef struct packed {
      logic [CNT_W-1:0]                  flash_cnt;
      logic                              flash_ph;
      logic [2*N_COMM-1:0][CNT_W-1:0]    act_cnt;
      logic                              wr_pend;
      logic [ADDR_W-1:0]                 wr_addr;
      logic [31:0]                       hrdata;
      logic                              hready;
      logic                              comm_en;
      logic [N_IRQ-1:0]                  irq_stat;
      logic [N_IRQ-1:0]                  irq_en;
      logic                              irq;
      logic                              prev_fail;
      logic                              prev_cfg;
      logic                              prev_act;
      logic                              prev_stby;
      msld_led_type                      led;
   } msld_state_type;
endpackage : msld_pkg
`default_nettype wire

/* File: hw/msld_top.sv */
// Summary of operation
// - Ten indicators are driven: health, active, standby, config and six comm.
// - Health is steady green when healthy and flashes red on slice failure.
// - Active is steady green while the module is in active mode.
// - In the middle build standby is steady green while in standby mode.
// - In the middle build config lights once configuration has loaded.
// - In early and late builds standby is dark and config is always green.
// - Early builds flash red on transmit and green on receive per port.
// - Early builds show steady green on an idle Ethernet port without a link.
// - Later serial ports flash red on tx, green on rx and amber on both.
// - Late builds give four indicators to the serial ports.
// - Late builds give two Ethernet indicators and drive only their green.
// - Late Ethernet green blinks with traffic and looks solid when busy.
// - Late Ethernet indicators are off while no data moves.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module msld_top #(
   parameter msld_pkg::msld_build_type BUILD = msld_pkg::BUILD_LATE,
   parameter int FLASH_HALF_CYC =
      msld_pkg::CLK_HZ / msld_pkg::MS_PER_S * msld_pkg::FLASH_HALF_MS,
   parameter int STRETCH_CYC =
      msld_pkg::CLK_HZ / msld_pkg::MS_PER_S * msld_pkg::STRETCH_MS
) (
   input  wire logic                  CLOCK_I,
   input  wire logic                  RESET_I,
   input  wire msld_pkg::msld_core_type CORE_I,
   input  wire msld_pkg::msld_act_type  ACT_I,
   input  wire logic                  HSEL_I,
   input  wire logic [31:0]           HADDR_I,
   input  wire logic [1:0]            HTRANS_I,
   input  wire logic                  HWRITE_I,
   input  wire logic [2:0]            HSIZE_I,
   input  wire logic [31:0]           HWDATA_I,
   input  wire logic                  HREADY_I,
   output logic [31:0]                HRDATA_O,
   output logic                       HREADYOUT_O,
   output logic                       HRESP_O,
   output logic                       IRQ_O,
   output msld_pkg::msld_led_type     LED_O
);
   localparam int CW = msld_pkg::CNT_W;
   localparam int NC = msld_pkg::N_COMM;
   localparam logic [CW-1:0] FLASH_RELOAD = CW'(FLASH_HALF_CYC - 1);
   localparam logic [CW-1:0] STRETCH_LOAD = CW'(STRETCH_CYC);
   localparam logic [CW-1:0] STRETCH_HALF = CW'(STRETCH_CYC / 2);
   localparam logic is_early = (BUILD == msld_pkg::BUILD_EARLY);
   localparam logic is_mid   = (BUILD == msld_pkg::BUILD_MID);
   localparam logic is_late  = (BUILD == msld_pkg::BUILD_LATE);

   msld_pkg::msld_state_type s;
   msld_pkg::msld_state_type n;

   function automatic logic [CW-1:0] stretch_next(
      input logic [CW-1:0] cnt,
      input logic          ev
   );
      logic [CW-1:0] r;
      r = cnt;
      if (ev)
      begin
         r = STRETCH_LOAD;
      end
      else if (cnt != '0)
      begin
         r = cnt - 1'b1;
      end
      return r;
   endfunction : stretch_next

   function automatic logic [31:0] read_mux(
      input logic [msld_pkg::ADDR_W-1:0] a,
      input msld_pkg::msld_state_type    st
   );
      logic [31:0] r;
      r = '0;
      unique case (a)
         msld_pkg::A_CTRL:     r[msld_pkg::CTRL_COMM_EN] = st.comm_en;
         msld_pkg::A_LED_STAT: r = 32'(st.led);
         msld_pkg::A_IRQ_STAT: r = 32'(st.irq_stat);
         msld_pkg::A_IRQ_EN:   r = 32'(st.irq_en);
         default:              r = '0;
      endcase
      return r;
   endfunction : read_mux

   always_comb
   begin
      logic             tx_b;
      logic             rx_b;
      logic [msld_pkg::N_IRQ-1:0] ev;
      logic [msld_pkg::N_IRQ-1:0] clr;
      logic             take;
      tx_b = 1'b0;
      rx_b = 1'b0;
      ev   = '0;
      clr  = '0;
      take = 1'b0;
      n = s;

      // Shared flash phase generator
      if (s.flash_cnt == '0)
      begin
         n.flash_cnt = FLASH_RELOAD;
         n.flash_ph  = ~s.flash_ph;
      end
      else
      begin
         n.flash_cnt = s.flash_cnt - 1'b1;
      end

      for (int k = 0; k < NC; k++)
      begin
         n.act_cnt[k]      = stretch_next(s.act_cnt[k], ACT_I.tx[k]);
         n.act_cnt[k + NC] = stretch_next(s.act_cnt[k + NC], ACT_I.rx[k]);
      end

      n.led.health_g  = ~CORE_I.slice_fail;
      n.led.health_r  = CORE_I.slice_fail & s.flash_ph;
      n.led.active_g  = CORE_I.active;
      n.led.standby_g = is_mid & CORE_I.standby;
      n.led.config_g  = is_mid ? CORE_I.cfg_loaded : 1'b1;

      // Ports 0..3 serial, 4..5 Ethernet
      for (int k = 0; k < NC; k++)
      begin
         tx_b = s.act_cnt[k] != '0;
         rx_b = s.act_cnt[k + NC] != '0;
         n.led.red[k]   = tx_b & s.flash_ph;
         n.led.green[k] = rx_b & s.flash_ph;
         if (k >= msld_pkg::N_SER)
         begin
            if (is_early && !CORE_I.eth_link[k - msld_pkg::N_SER] &&
                !tx_b && !rx_b)
            begin
               n.led.green[k] = 1'b1;
            end
            if (is_late)
            begin
               n.led.red[k]   = 1'b0;
               n.led.green[k] = (s.act_cnt[k] > STRETCH_HALF) ||
                                (s.act_cnt[k + NC] > STRETCH_HALF);
            end
         end
         if (!s.comm_en)
         begin
            n.led.red[k]   = 1'b0;
            n.led.green[k] = 1'b0;
         end
      end

      // Interrupt events on rising fail, config load and mode change
      n.prev_fail = CORE_I.slice_fail;
      n.prev_cfg  = CORE_I.cfg_loaded;
      n.prev_act  = CORE_I.active;
      n.prev_stby = CORE_I.standby;
      ev[msld_pkg::IRQ_FAIL] = CORE_I.slice_fail & ~s.prev_fail;
      ev[msld_pkg::IRQ_CFG]  = CORE_I.cfg_loaded & ~s.prev_cfg;
      ev[msld_pkg::IRQ_MODE] = (CORE_I.active ^ s.prev_act) |
                               (CORE_I.standby ^ s.prev_stby);

      // Data phase of a pending write
      n.wr_pend = 1'b0;
      if (s.wr_pend)
      begin
         unique case (s.wr_addr)
            msld_pkg::A_CTRL:
               n.comm_en = HWDATA_I[msld_pkg::CTRL_COMM_EN];
            msld_pkg::A_IRQ_EN:
               n.irq_en = HWDATA_I[msld_pkg::N_IRQ-1:0];
            msld_pkg::A_IRQ_CLR:
               clr = HWDATA_I[msld_pkg::N_IRQ-1:0];
            default: ;
         endcase
      end
      // Set wins over clear
      n.irq_stat = (s.irq_stat & ~clr) | ev;
      n.irq      = |(n.irq_stat & n.irq_en);

      // Address phase; reads see any write finished this cycle
      take = HSEL_I & HTRANS_I[1] & HREADY_I;
      if (take && HWRITE_I)
      begin
         n.wr_pend = 1'b1;
         n.wr_addr = HADDR_I[msld_pkg::ADDR_W-1:0];
      end
      if (take && !HWRITE_I)
      begin
         n.hrdata = read_mux(HADDR_I[msld_pkg::ADDR_W-1:0], n);
      end
      n.hready = 1'b1;

      if (RESET_I)
      begin
         n = '0;
         n.flash_cnt = FLASH_RELOAD;
         n.comm_en   = msld_pkg::CTRL_COMM_EN_RST;
         n.hready    = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      s <= n;
   end

   assign HRDATA_O    = s.hrdata;
   assign HREADYOUT_O = s.hready;
   assign HRESP_O     = msld_pkg::HRESP_OKAY[0];
   assign IRQ_O       = s.irq;
   assign LED_O       = s.led;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RESET_I);

   chk_health_fail: assert property (
      CORE_I.slice_fail |=>
         !s.led.health_g && s.led.health_r == $past(s.flash_ph))
      else $error("health indicator wrong during failure");
   chk_health_ok: assert property (
      !CORE_I.slice_fail |=> s.led.health_g && !s.led.health_r)
      else $error("health indicator not steady green");
   chk_active_led: assert property (
      1'b1 |=> s.led.active_g == $past(CORE_I.active))
      else $error("active indicator does not follow mode");
   chk_standby_led: assert property (
      1'b1 |=> s.led.standby_g == (is_mid && $past(CORE_I.standby)))
      else $error("standby indicator wrong");
   chk_config_led: assert property (
      1'b1 |=> s.led.config_g == (!is_mid || $past(CORE_I.cfg_loaded)))
      else $error("config indicator wrong");
   chk_stretch_load: assert property (
      ACT_I.tx[0] |=> s.act_cnt[0] == STRETCH_LOAD)
      else $error("activity stretch not loaded");
   chk_red_cause: assert property (
      s.led.red[0] |-> $past(s.act_cnt[0]) != '0)
      else $error("red shown without transmit activity");
   chk_amber_both: assert property (
      !is_early && s.comm_en && s.flash_ph &&
      s.act_cnt[0] != '0 && s.act_cnt[NC] != '0 |=>
         s.led.red[0] && s.led.green[0])
      else $error("amber not shown for tx and rx");
   chk_eth_nolink: assert property (
      is_early && s.comm_en && !CORE_I.eth_link[0] &&
      s.act_cnt[4] == '0 && s.act_cnt[4 + NC] == '0 |=> s.led.green[4])
      else $error("no-link green missing");
   chk_eth_no_red: assert property (
      is_late |-> s.led.red[5:4] == 2'h0)
      else $error("Ethernet red driven in late build");
   chk_eth_busy_on: assert property (
      is_late && s.comm_en && ACT_I.tx[4] |=> ##1 s.led.green[4])
      else $error("Ethernet green missing under traffic");
   chk_eth_idle_off: assert property (
      is_late && s.act_cnt[4] == '0 && s.act_cnt[4 + NC] == '0 |=>
         !s.led.green[4])
      else $error("Ethernet indicator lit while idle");
   // Further indicator checks, register side and event guards
   chk_comm_blank: assert property (
      !s.comm_en |=> s.led.red == '0 && s.led.green == '0)
      else $error("comm indicators lit while blanked");
   chk_config_mid: assert property (
      is_mid && CORE_I.cfg_loaded |=> s.led.config_g)
      else $error("config indicator dark after load");
   chk_standby_dark: assert property (
      !is_mid |-> !s.led.standby_g)
      else $error("standby indicator lit outside middle build");
   chk_green_cause: assert property (
      s.led.green[0] |-> $past(s.act_cnt[NC]) != '0)
      else $error("green shown without receive activity");
   chk_eth_link_dark: assert property (
      is_early && CORE_I.eth_link[0] &&
      s.act_cnt[4] == '0 && s.act_cnt[4 + NC] == '0 |=> !s.led.green[4])
      else $error("green lit on linked idle port");
   chk_late_ser_red: assert property (
      is_late && s.comm_en && s.flash_ph && s.act_cnt[0] != '0 |=>
         s.led.red[0])
      else $error("late serial red missing");
   chk_fail_event: assert property (
      CORE_I.slice_fail && !s.prev_fail |=>
         s.irq_stat[msld_pkg::IRQ_FAIL])
      else $error("failure event not latched");
   chk_cfg_event: assert property (
      CORE_I.cfg_loaded && !s.prev_cfg |=>
         s.irq_stat[msld_pkg::IRQ_CFG])
      else $error("config event not latched");
   chk_mode_event: assert property (
      CORE_I.active != s.prev_act |=> s.irq_stat[msld_pkg::IRQ_MODE])
      else $error("mode event not latched");
   chk_irq_level: assert property (
      1'b1 |-> IRQ_O == |(s.irq_stat & s.irq_en))
      else $error("interrupt level wrong");
   chk_ctrl_write: assert property (
      s.wr_pend && s.wr_addr == msld_pkg::A_CTRL |=>
         s.comm_en == $past(HWDATA_I[msld_pkg::CTRL_COMM_EN]))
      else $error("control write did not land");
   chk_ready_high: assert property (
      1'b1 |-> HREADYOUT_O)
      else $error("bus ready dropped");
endmodule : msld_top
`default_nettype wire

/* File: tb/msld_panel.sv */
`default_nettype none
module msld_panel
(
   input  wire msld_pkg::msld_led_type   led_i,
   output logic [2*msld_pkg::N_COMM-1:0] hue_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Two bits per comm lamp, red over green; both lit reads amber
   always_comb
   begin
      for (int i = 0; i < msld_pkg::N_COMM; i++)
      begin
         hue_o[2*i+:2] = {led_i.red[i], led_i.green[i]};
      end
   end
endmodule : msld_panel
`default_nettype wire

/* File: tb/msld_top_test.sv */
`default_nettype none
`define CHK(n, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         $display("MISMATCH %s exp %0h got %0h", n, e, g); \
         failures++; \
      end \
   end
module msld_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FH = 8;
   localparam int ST = 6;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   msld_pkg::msld_core_type core = '0;
   msld_pkg::msld_act_type act = '0;
   logic                   hsel = 1'b0;
   logic [31:0]            haddr = '0;
   logic [1:0]             htrans = '0;
   logic                   hwrite = 1'b0;
   logic [31:0]            hwdata = '0;
   logic [31:0]            rdat;
   logic [31:0]            hrdata [3];
   logic                   hready [3];
   logic                   irq [3];
   logic                   hresp [3];
   msld_pkg::msld_led_type led [3];
   msld_pkg::msld_led_type seen [3];
   msld_pkg::msld_led_type allhi [3];
   logic [11:0]            hue;
   logic                   amb;
   int                     failures = 0;
   int                     cmp_count = 0;
   int                     cyc = 0;

   always #12.5 clk = ~clk;

   for (genvar g = 0; g < 3; g++)
   begin : gen_b
      msld_top #(
         .BUILD          (msld_pkg::msld_build_type'(3'h1 << g)),
         .FLASH_HALF_CYC (FH),
         .STRETCH_CYC    (ST)
      ) dut_u (
         .CLOCK_I     (clk),
         .RESET_I     (rst),
         .CORE_I      (core),
         .ACT_I       (act),
         .HSEL_I      (hsel),
         .HADDR_I     (haddr),
         .HTRANS_I    (htrans),
         .HWRITE_I    (hwrite),
         .HSIZE_I     (3'h2),
         .HWDATA_I    (hwdata),
         .HREADY_I    (hready[g]),
         .HRDATA_O    (hrdata[g]),
         .HREADYOUT_O (hready[g]),
         .HRESP_O     (hresp[g]),
         .IRQ_O       (irq[g]),
         .LED_O       (led[g])
      );
   end

   msld_panel pnl_u (.led_i (led[2]), .hue_o (hue));

   task give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task watch(input int n);
      amb = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         seen[k] = '0;
         allhi[k] = '1;
      end
      repeat (n)
      begin
         @(negedge clk);
         amb = amb | (hue[1:0] == 2'h3);
         for (int k = 0; k < 3; k++)
         begin
            seen[k] = seen[k] | led[k];
            allhi[k] = allhi[k] & led[k];
         end
      end
   endtask : watch

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready[2] !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready[2] !== 1'b1);
      rdat = hrdata[2];
      `CHK("hresp", 1'b0, hresp[2])
   endtask : ahb

   task settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task t_modes();
      @(posedge clk);
      core <= '{1'b0, 1'b1, 1'b1, 1'b0, 2'h3};
      settle();
      watch(4);
      for (int k = 0; k < 3; k++)
      begin
         `CHK("health_g", 1'b1, allhi[k].health_g)
         `CHK("active_g", 1'b1, allhi[k].active_g)
         `CHK("standby_g", k == 1, seen[k].standby_g)
         `CHK("config_g", k != 1, allhi[k].config_g)
      end
      @(posedge clk);
      core.cfg_loaded <= 1'b1;
      core.active <= 1'b0;
      core.standby <= 1'b0;
      settle();
      watch(4);
      `CHK("config_g", 1'b1, allhi[1].config_g)
      `CHK("active_g", 1'b0, seen[1].active_g)
      `CHK("standby_g", 1'b0, seen[1].standby_g)
      ahb(1'b0, msld_pkg::A_IRQ_STAT, 32'h0);
      `CHK("irq_stat modes", 32'h6, rdat)
      ahb(1'b0, msld_pkg::A_LED_STAT, 32'h0);
      `CHK("led_stat", 32'h9000, rdat)
      $display("t_modes done");
   endtask : t_modes

   task t_fail();
      ahb(1'b1, msld_pkg::A_IRQ_CLR, 32'h7);
      ahb(1'b1, msld_pkg::A_IRQ_EN, 32'h1);
      ahb(1'b0, msld_pkg::A_IRQ_EN, 32'h0);
      `CHK("irq_en", 32'h1, rdat)
      @(posedge clk);
      core.slice_fail <= 1'b1;
      settle();
      watch(4 * FH);
      `CHK("health_r on", 1'b1, seen[2].health_r)
      `CHK("health_r off", 1'b0, allhi[2].health_r)
      `CHK("health_g", 1'b0, seen[2].health_g)
      `CHK("irq", 1'b1, irq[2])
      ahb(1'b0, msld_pkg::A_IRQ_STAT, 32'h0);
      `CHK("irq_stat", 32'h1, rdat)
      ahb(1'b1, msld_pkg::A_IRQ_EN, 32'h0);
      settle();
      `CHK("irq masked", 1'b0, irq[2])
      ahb(1'b1, msld_pkg::A_IRQ_EN, 32'h1);
      settle();
      `CHK("irq unmasked", 1'b1, irq[2])
      ahb(1'b1, msld_pkg::A_IRQ_CLR, 32'h1);
      settle();
      `CHK("irq cleared", 1'b0, irq[2])
      @(posedge clk);
      core.slice_fail <= 1'b0;
      $display("t_fail done");
   endtask : t_fail

   task t_comm();
      for (int m = 1; m < 4; m++)
      begin
         @(posedge clk);
         act <= '0;
         repeat (ST + 2) @(posedge clk);
         act.tx[0] <= m[0];
         act.rx[0] <= m[1];
         settle();
         watch(3 * FH);
         for (int k = 0; k < 3; k++)
         begin
            `CHK("ser red", m[0], seen[k].red[0])
            `CHK("ser green", m[1], seen[k].green[0])
         end
         `CHK("amber", m == 3, amb)
      end
      @(posedge clk);
      act <= '0;
      repeat (ST + 2) @(posedge clk);
      watch(3 * FH);
      `CHK("ser idle", 1'b0, seen[2].red[0] | seen[2].green[0])
      $display("t_comm done");
   endtask : t_comm

   task t_eth();
      @(posedge clk);
      act.tx[4] <= 1'b1;
      @(posedge clk);
      act.tx[4] <= 1'b0;
      watch(ST + 4);
      `CHK("eth pulse", 1'b1, seen[2].green[4])
      `CHK("eth red", 1'b0, seen[2].red[4])
      watch(4);
      `CHK("eth idle", 1'b0, seen[2].green[4])
      @(posedge clk);
      act.rx[5] <= 1'b1;
      settle();
      watch(3 * FH);
      `CHK("eth solid", 1'b1, allhi[2].green[5])
      `CHK("eth red", 1'b0, seen[2].red[5])
      @(posedge clk);
      act.rx[5] <= 1'b0;
      core.eth_link <= 2'h0;
      repeat (ST + 2) @(posedge clk);
      watch(4);
      `CHK("no link", 1'b1, allhi[0].green[4])
      $display("t_eth done");
   endtask : t_eth

   task t_regs();
      ahb(1'b0, msld_pkg::A_CTRL, 32'h0);
      `CHK("ctrl rst", 32'h1, rdat)
      ahb(1'b1, 8'h14, 32'hffffffff);
      ahb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 32'h0, rdat)
      ahb(1'b1, msld_pkg::A_CTRL, 32'h0);
      @(posedge clk);
      act.tx[1] <= 1'b1;
      settle();
      watch(3 * FH);
      `CHK("blanked", 1'b0, seen[2].red[1])
      ahb(1'b1, msld_pkg::A_CTRL, 32'h1);
      settle();
      watch(3 * FH);
      `CHK("unblanked", 1'b1, seen[2].red[1])
      $display("t_regs done");
   endtask : t_regs

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_modes();
      t_fail();
      t_comm();
      t_eth();
      t_regs();
      give_verdict();
   end
endmodule : msld_top_test
`default_nettype wire
